/* File: hdl/tpwm_pkg.sv */
/*
 * Constants shared by the six-channel timer and its channel slice.
 * Assumes one 125 MHz bus clock and an APB master with 32-bit data.
 */
// Functional notes
// - Buffered even channel pairs with next odd.
// - Last written channel governs from next rollover.
// - Linked odd channel control unused, pin released.
// - Mode 01 unbuffered, 10 buffered compare.
// - Action 10 clears, 11 sets on compare.
// - Buffered bit beats unbuffered bit on even.
// - No rollover toggle with clear on compare gives zero duty.
// - Full duty bit without toggle holds high.
// - Rollover flag on wrap, optional interrupt.
// - Channel flag on compare or capture, interrupt.
// - Wait mode counts, blocks access, interrupts wake.
// - Stop mode halts, keeps state, resumes.
// - Break freezes counter and suppresses captures.
// - Break clear enable governs flag clearing.
// - Armed two-step clear finishes after break.
// - Prescale code 111 uses external pin.
// - Pins independent except the odd pin of a buffered pair; even pins carry buffered.
// - Read-then-write-zero clear, cancelled by a new event of the same flag.
// - Halt bit holds counter, set by reset.
// - Counter clear bit zeroes counter, reads zero.
// - Prescale codes 000-110 divide by 1..64.
`default_nettype none
package tpwm_pkg;
	localparam int NCH = 6;
	localparam logic [11:0] ADDR_TCS = 12'h000;
	localparam logic [11:0] ADDR_CNT = 12'h004;
	localparam logic [11:0] ADDR_LIM = 12'h008;
	localparam logic [11:0] ADDR_CCS = 12'h020;
	localparam logic [11:0] ADDR_CVAL = 12'h040;
	localparam int TCS_FLAG = 7;
	localparam int TCS_IE = 6;
	localparam int TCS_HALT = 5;
	localparam int TCS_CLR = 4;
	localparam int CC_FLAG = 7;
	localparam int CC_IE = 6;
	localparam int CC_BUF = 5;
	localparam int CC_UNB = 4;
	localparam int CC_ELH = 3;
	localparam int CC_ELL = 2;
	localparam int CC_TOV = 1;
	localparam int CC_MAX = 0;
	localparam logic [15:0] LIM_RST = 16'hffff;
	localparam logic HALT_RST = 1'b1;
	localparam logic [2:0] PS_EXT = 3'h7;
	localparam logic [1:0] ACT_TGL = 2'h1;
	localparam logic [1:0] ACT_CLR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
endpackage
`default_nettype wire

/* File: hdl/tpwm_chan.sv */
/*
 * One timer channel: output compare with rollover toggle, or input capture.
 * Assumes tick and wrap come from the shared counter on the same clock.
 */
`default_nettype none
module tpwm_chan #(
	parameter int W = 16,
	parameter bit IS_EVEN = 1'b1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Counter timing
	input wire logic tick,
	input wire logic wrap,
	input wire logic cap_en,
	input wire logic [W-1:0] cnt,
	input wire logic [W-1:0] cmp_val,
	// Channel control
	input wire logic [5:0] ctrl,
	input wire logic silenced,
	// Pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	// Events
	output logic cmp_evt,
	output logic cap_evt
);
	import tpwm_pkg::*;
	logic [1:0] act;
	logic oc;
	logic [2:0] sync_ff;
	logic out_ff;
	logic nxt_out;

	assign act = ctrl[CC_ELH:CC_ELL];
	assign oc = ~silenced & (ctrl[CC_UNB] | (IS_EVEN & ctrl[CC_BUF]));
	assign cmp_evt = oc & tick & (cnt == cmp_val);
	assign pin_oe = oc & (act != 2'h0);
	assign pin_out = out_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_ff <= 3'h0;
		end else begin
			sync_ff <= {sync_ff[1:0], pin_in};
		end
	end

	assign cap_evt = ~oc & ~silenced & cap_en &
		((act[0] & sync_ff[1] & ~sync_ff[2]) | (act[1] & ~sync_ff[1] & sync_ff[2]));

	always_comb begin
		nxt_out = out_ff;
		if (wrap & ctrl[CC_TOV]) begin
			nxt_out = ~out_ff;
		end
		if (cmp_evt) begin
			if (act == ACT_TGL) begin
				nxt_out = ~nxt_out;
			end else if (act == ACT_CLR) begin
				nxt_out = 1'b0;
			end else if (act == ACT_SET) begin
				nxt_out = 1'b1;
			end
		end
		if (ctrl[CC_MAX] & ~ctrl[CC_TOV]) begin
			nxt_out = 1'b1;
		end
		if (~oc) begin
			nxt_out = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ff <= 1'b0;
		end else begin
			out_ff <= nxt_out;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_full_duty;
		oc & ctrl[CC_MAX] & ~ctrl[CC_TOV] |=> out_ff;
	endproperty
	a_full_duty: assert property (p_full_duty) else $error("full duty not held");

	property p_zero_duty;
		oc & ~ctrl[CC_TOV] & ~ctrl[CC_MAX] & ~out_ff & (act != ACT_SET) & (act != ACT_TGL) [*2]
			|=> ~out_ff;
	endproperty
	a_zero_duty: assert property (p_zero_duty) else $error("zero duty output rose");

	property p_wrap_toggle;
		oc & wrap & ctrl[CC_TOV] & ~ctrl[CC_MAX] & ~cmp_evt |=> out_ff != $past(out_ff);
	endproperty
	a_wrap_toggle: assert property (p_wrap_toggle) else $error("no toggle at wrap");
endmodule
`default_nettype wire

/* File: hdl/tpwm_top.sv */
/*
 * Six-channel timer with PWM, buffered pairs and an APB register port.
 * Assumes the system supplies wait, stop and break levels on pclk and
 * that pins come from outside the clock domain.
 */
`default_nettype none
module tpwm_top (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// System modes
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic break_active,
	input wire logic break_clear_enable,
	// External count clock
	input wire logic ext_count_clock_pin,
	output logic ext_clk_force_input,
	// Channel pins
	input wire logic [tpwm_pkg::NCH-1:0] chan_pin_in,
	output logic [tpwm_pkg::NCH-1:0] chan_pin_out,
	output logic [tpwm_pkg::NCH-1:0] chan_pin_oe,
	// Interrupt request
	output logic timer_irq
);
	import tpwm_pkg::*;

	function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] base);
		reg_hit = (a[11:5] == base[11:5]) && (a[1:0] == 2'h0) && (a[4:2] < 3'(NCH));
	endfunction

	logic acc, rd, wr, setup;
	logic tcs_hit, cnt_hit, lim_hit, cc_hit, cv_hit, mapped;
	logic [2:0] idx;
	logic [31:0] rdmux;
	logic [31:0] prdata_ff;
	logic halt_ff, oie_ff;
	logic [2:0] ps_ff;
	logic [6:0] pre_ff;
	logic [6:0] pre_mask;
	logic [15:0] cnt_ff, lim_ff;
	logic [2:0] ext_ff;
	logic run, tick, wrap, clr_req, ext_edge, clr_ok;
	logic [6:0] cc_ff [NCH];
	logic [15:0] val_ff [NCH];
	logic [NCH:0] flag_ff, arm_ff, evt, rd_hit, wr_hit, en;
	logic [NCH-1:0] cmp_evt, cap_evt;
	logic [2:0] sel_ff, pend_ff;

	assign acc = psel & penable;
	assign setup = psel & ~penable;
	assign rd = acc & ~pwrite & ~wait_mode;
	assign wr = acc & pwrite & ~wait_mode;
	assign idx = paddr[4:2];
	assign tcs_hit = paddr == ADDR_TCS;
	assign cnt_hit = paddr == ADDR_CNT;
	assign lim_hit = paddr == ADDR_LIM;
	assign cc_hit = reg_hit(paddr, ADDR_CCS);
	assign cv_hit = reg_hit(paddr, ADDR_CVAL);
	assign mapped = tcs_hit | cnt_hit | lim_hit | cc_hit | cv_hit;
	assign pready = 1'b1;
	assign pslverr = acc & (~mapped | wait_mode);
	assign prdata = prdata_ff;

	always_comb begin
		rdmux = 32'h0;
		if (tcs_hit) begin
			rdmux[TCS_FLAG] = flag_ff[NCH];
			rdmux[TCS_IE] = oie_ff;
			rdmux[TCS_HALT] = halt_ff;
			rdmux[2:0] = ps_ff;
		end else if (cnt_hit) begin
			rdmux[15:0] = cnt_ff;
		end else if (lim_hit) begin
			rdmux[15:0] = lim_ff;
		end else if (cc_hit) begin
			rdmux[7:0] = {flag_ff[idx], cc_ff[idx]};
		end else if (cv_hit) begin
			rdmux[15:0] = val_ff[idx];
		end
		if (wait_mode) begin
			rdmux = 32'h0;
		end
	end

	// Data is sampled in the setup cycle so that reads need no wait state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
		end else if (setup) begin
			prdata_ff <= rdmux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_ff <= HALT_RST;
			oie_ff <= 1'b0;
			ps_ff <= 3'h0;
		end else if (wr & tcs_hit) begin
			halt_ff <= pwdata[TCS_HALT];
			oie_ff <= pwdata[TCS_IE];
			ps_ff <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_ff <= LIM_RST;
		end else if (wr & lim_hit) begin
			lim_ff <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCH; i++) begin
				cc_ff[i] <= 7'h0;
			end
		end else if (wr & cc_hit) begin
			cc_ff[idx] <= pwdata[6:0];
		end
	end

	// A capture in the same cycle as a software write keeps the captured count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCH; i++) begin
				val_ff[i] <= 16'h0;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (cap_evt[i]) begin
					val_ff[i] <= cnt_ff;
				end else if (wr & cv_hit & (idx == 3'(i))) begin
					val_ff[i] <= pwdata[15:0];
				end
			end
		end
	end

	assign ext_clk_force_input = ps_ff == PS_EXT;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_ff <= 3'h0;
		end else begin
			ext_ff <= {ext_ff[1:0], ext_count_clock_pin};
		end
	end

	assign ext_edge = ext_ff[1] & ~ext_ff[2];
	assign run = ~halt_ff & ~stop_mode & ~break_active;
	assign clr_req = wr & tcs_hit & pwdata[TCS_CLR];
	assign pre_mask = 7'((8'h01 << ps_ff) - 8'h01);
	assign tick = run & (ext_clk_force_input ? ext_edge : ((pre_ff & pre_mask) == pre_mask));
	assign wrap = tick & (cnt_ff == lim_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= 7'h0;
		end else if (clr_req) begin
			pre_ff <= 7'h0;
		end else if (run) begin
			pre_ff <= pre_ff + 7'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 16'h0;
		end else if (clr_req) begin
			cnt_ff <= 16'h0;
		end else if (wrap) begin
			cnt_ff <= 16'h0;
		end else if (tick) begin
			cnt_ff <= cnt_ff + 16'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_ff <= 3'h0;
			pend_ff <= 3'h0;
		end else begin
			for (int p = 0; p < NCH / 2; p++) begin
				if (!cc_ff[2 * p][CC_BUF]) begin
					sel_ff[p] <= 1'b0;
					pend_ff[p] <= 1'b0;
				end else if (wr & cv_hit & (idx == 3'(2 * p + 1))) begin
					pend_ff[p] <= 1'b1;
					if (wrap) begin
						sel_ff[p] <= 1'b1;
					end
				end else if (wr & cv_hit & (idx == 3'(2 * p))) begin
					pend_ff[p] <= 1'b0;
					if (wrap) begin
						sel_ff[p] <= 1'b0;
					end
				end else if (wrap) begin
					sel_ff[p] <= pend_ff[p];
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic silenced;
			logic [15:0] cmp_val;
			if (g % 2 == 0) begin : g_even
				assign silenced = 1'b0;
				assign cmp_val = (cc_ff[g][CC_BUF] & sel_ff[g / 2]) ? val_ff[g + 1] : val_ff[g];
			end else begin : g_odd
				assign silenced = cc_ff[g - 1][CC_BUF];
				assign cmp_val = val_ff[g];
			end
			tpwm_chan #(
				.W(16),
				.IS_EVEN(g % 2 == 0)
			) i_tpwm_chan (
				.pclk(pclk),
				.presetn(presetn),
				.tick(tick),
				.wrap(wrap),
				.cap_en(run),
				.cnt(cnt_ff),
				.cmp_val(cmp_val),
				.ctrl(cc_ff[g][5:0]),
				.silenced(silenced),
				.pin_in(chan_pin_in[g]),
				.pin_out(chan_pin_out[g]),
				.pin_oe(chan_pin_oe[g]),
				.cmp_evt(cmp_evt[g]),
				.cap_evt(cap_evt[g])
			);
			assign evt[g] = cmp_evt[g] | cap_evt[g];
			assign rd_hit[g] = rd & cc_hit & (idx == 3'(g));
			assign wr_hit[g] = wr & cc_hit & (idx == 3'(g)) & ~pwdata[CC_FLAG];
			assign en[g] = cc_ff[g][CC_IE];
		end
	endgenerate

	assign evt[NCH] = wrap;
	assign rd_hit[NCH] = rd & tcs_hit;
	assign wr_hit[NCH] = wr & tcs_hit & ~pwdata[TCS_FLAG];
	assign en[NCH] = oie_ff;
	assign clr_ok = ~break_active | break_clear_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_ff <= '0;
			arm_ff <= '0;
		end else begin
			for (int i = 0; i <= NCH; i++) begin
				if (evt[i]) begin
					flag_ff[i] <= 1'b1;
					arm_ff[i] <= 1'b0;
				end else if (clr_ok & wr_hit[i] & arm_ff[i]) begin
					flag_ff[i] <= 1'b0;
					arm_ff[i] <= 1'b0;
				end else if (clr_ok & rd_hit[i] & flag_ff[i]) begin
					arm_ff[i] <= 1'b1;
				end
			end
		end
	end

	assign timer_irq = |(flag_ff & en);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_flag_set;
		wrap |=> flag_ff[NCH];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("rollover flag missed");

	property p_wrap_zero;
		wrap & ~clr_req |=> cnt_ff == 16'h0;
	endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not wrap");

	property p_halt;
		halt_ff & ~clr_req |=> $stable(cnt_ff);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted");

	property p_clear;
		clr_req |=> (cnt_ff == 16'h0) && (pre_ff == 7'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("counter clear failed");

	property p_freeze;
		(break_active | stop_mode) & ~clr_req |-> (cap_evt == '0) ##1 $stable(cnt_ff);
	endproperty
	a_freeze: assert property (p_freeze) else $error("counter ran in break or stop");

	property p_protect;
		break_active & ~break_clear_enable & flag_ff[NCH] |=> flag_ff[NCH];
	endproperty
	a_protect: assert property (p_protect) else $error("flag cleared under protection");

	property p_irq;
		flag_ff[1] & cc_ff[1][CC_IE] |-> timer_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("channel interrupt missing");

	property p_odd_off;
		cc_ff[4][CC_BUF] |-> ~chan_pin_oe[5];
	endproperty
	a_odd_off: assert property (p_odd_off) else $error("linked odd pin driven");

	property p_pair;
		cc_ff[4][CC_BUF] & wrap & pend_ff[2] & ~wr |=> sel_ff[2];
	endproperty
	a_pair: assert property (p_pair) else $error("pair did not switch");

	property p_ext;
		run & ext_clk_force_input & ~ext_edge |-> ~tick;
	endproperty
	a_ext: assert property (p_ext) else $error("tick without pin edge");

	c_wrap: cover property (wrap);
	c_switch: cover property (wrap & pend_ff[2] & ~sel_ff[2]);
	c_clear: cover property (flag_ff[NCH] ##1 ~flag_ff[NCH]);
	c_ext: cover property (tick & ext_clk_force_input);
endmodule
`default_nettype wire

/* File: sim/tpwm_pins_model.sv */
/*
 * Pin-side model of the circuits around the timer: an external count clock
 * source and input drivers on the six channel pins.
 * Assumes its tasks are called just after a rising edge of pclk.
 */
`default_nettype none
module tpwm_pins_model (
	// Clock
	input wire logic pclk,
	// Channel pins
	input wire logic [tpwm_pkg::NCH-1:0] chan_pin_out,
	input wire logic [tpwm_pkg::NCH-1:0] chan_pin_oe,
	output logic [tpwm_pkg::NCH-1:0] chan_pin_in,
	// External count clock
	output logic ext_count_clock_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	import tpwm_pkg::*;
	logic [NCH-1:0] drive_ff;
	// The wire follows the timer where it drives and the outside circuit elsewhere.
	assign chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & drive_ff);
	initial begin
		drive_ff = '0;
		ext_count_clock_pin = 1'b0;
	end
	// slow pin clock
	// Each level lasts four bus cycles so the synchroniser never misses one.
	task automatic clock_burst(input int n);
		repeat (n) begin
			ext_count_clock_pin <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_count_clock_pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask
	task automatic pin_pulse(input int ch);
		drive_ff[ch] <= 1'b1;
		repeat (8) @(posedge pclk);
		drive_ff[ch] <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

/* File: sim/test_timer_pwm_channels.sv */
/*
 * Self-checking bench for the six-channel timer: APB register tasks, PWM
 * duty counts, prescaler, flags, low-power modes and capture.
 * Assumes the pin model beside the timer and a zero-wait APB slave.
 */
`default_nettype none
module test_timer_pwm_channels;
	timeunit 1ns;
	timeprecision 1ps;
	import tpwm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, force_in, ext_pin, e;
	logic wait_mode, stop_mode, break_active, bce;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, r0, r1;
	logic [NCH-1:0] pin_in, pin_out, pin_oe;
	int fails, samples_checked, h;

	tpwm_top i_tpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode),
		.break_active(break_active), .break_clear_enable(bce), .ext_count_clock_pin(ext_pin),
		.ext_clk_force_input(force_in), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
		.chan_pin_oe(pin_oe), .timer_irq(irq));
	tpwm_pins_model i_tpwm_pins_model (.pclk(pclk), .chan_pin_out(pin_out),
		.chan_pin_oe(pin_oe), .chan_pin_in(pin_in), .ext_count_clock_pin(ext_pin));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic close_out;
		$display("comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(r, exp);
	endtask
	// Settle two periods, then count high cycles over two periods of eight.
	task automatic hi(input int ch);
		h = 0;
		repeat (16) @(posedge pclk);
		repeat (16) begin
			@(negedge pclk);
			if (pin_out[ch] === 1'b1)
				h++;
		end
		@(posedge pclk);
	endtask

	initial begin
		#400000;
		fails++;
		close_out;
	end

	initial begin
		{presetn, psel, penable, pwrite, wait_mode, stop_mode, break_active, bce} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fails = 0;
		samples_checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		rd(ADDR_TCS, 32'h20);
		rd(ADDR_LIM, 32'hffff);
		rd(ADDR_CNT, 32'h0);
		rd(12'h0fc, 32'h0);
		check(e, 1'b1);
		wr(ADDR_TCS, 32'h30);
		wr(ADDR_LIM, 32'h7);
		wr(ADDR_CVAL, 32'h3);
		wr(ADDR_CCS, 32'h1a);
		wr(ADDR_TCS, 32'h0);
		hi(0);
		check(h, 8);
		rd(ADDR_CCS, 32'h9a);
		wr(ADDR_CCS, 32'h18);
		hi(0);
		check(h, 0);
		wr(ADDR_CCS, 32'h19);
		hi(0);
		check(h, 16);
		wr(ADDR_CCS, 32'h1e);
		hi(0);
		check(h, 8);
		wr(ADDR_CCS + 12'h14, 32'h1a);
		wr(ADDR_CVAL + 12'h10, 32'h2);
		wr(ADDR_CCS + 12'h10, 32'h3a);
		hi(4);
		check(h, 6);
		check(pin_oe[5:4], 2'b01);
		wr(ADDR_CVAL + 12'h14, 32'h5);
		hi(4);
		check(h, 12);
		wr(ADDR_CVAL + 12'h10, 32'h1);
		hi(4);
		check(h, 4);
		// The start and stop writes leave 256 enabled edges between them.
		wr(ADDR_LIM, 32'hffff);
		for (int c = 0; c < 7; c++) begin
			wr(ADDR_TCS, 32'h30);
			wr(ADDR_TCS, 32'(c));
			repeat (253) @(posedge pclk);
			wr(ADDR_TCS, 32'h20);
			apb(1'b0, ADDR_CNT, 32'h0);
			check(r + 32'h1 - (32'h100 >> c) <= 32'h2, 1'b1);
		end
		wr(ADDR_TCS, 32'h30);
		rd(ADDR_CNT, 32'h0);
		rd(ADDR_TCS, 32'ha0);
		wr(ADDR_TCS, 32'h27);
		check(force_in, 1'b1);
		wr(ADDR_TCS, 32'h7);
		i_tpwm_pins_model.clock_burst(5);
		repeat (8) @(posedge pclk);
		wr(ADDR_TCS, 32'h27);
		rd(ADDR_CNT, 32'h5);
		wr(ADDR_LIM, 32'h7);
		wr(ADDR_TCS, 32'h0);
		repeat (12) @(posedge pclk);
		wr(ADDR_TCS, 32'h60);
		check(irq, 1'b1);
		rd(ADDR_TCS, 32'he0);
		wr(ADDR_TCS, 32'he0);
		rd(ADDR_TCS, 32'he0);
		wr(ADDR_TCS, 32'h60);
		check(irq, 1'b0);
		rd(ADDR_TCS, 32'h60);
		wr(ADDR_TCS, 32'h0);
		repeat (12) @(posedge pclk);
		wr(ADDR_TCS, 32'h20);
		break_active <= 1'b1;
		rd(ADDR_TCS, 32'ha0);
		wr(ADDR_TCS, 32'h20);
		break_active <= 1'b0;
		rd(ADDR_TCS, 32'ha0);
		break_active <= 1'b1;
		repeat (4) @(posedge pclk);
		break_active <= 1'b0;
		wr(ADDR_TCS, 32'h20);
		rd(ADDR_TCS, 32'h20);
		bce <= 1'b1;
		wr(ADDR_TCS, 32'h0);
		repeat (12) @(posedge pclk);
		wr(ADDR_TCS, 32'h20);
		break_active <= 1'b1;
		rd(ADDR_TCS, 32'ha0);
		wr(ADDR_TCS, 32'h20);
		break_active <= 1'b0;
		rd(ADDR_TCS, 32'h20);
		bce <= 1'b0;
		wr(ADDR_LIM, 32'hffff);
		wr(ADDR_TCS, 32'h0);
		for (int k = 0; k < 3; k++) begin
			apb(1'b0, ADDR_CNT, 32'h0);
			r0 = r;
			{wait_mode, stop_mode, break_active} <= 3'b001 << k;
			@(posedge pclk);
			apb(1'b0, ADDR_CNT, 32'h0);
			r1 = r;
			repeat (20) @(posedge pclk);
			apb(1'b0, ADDR_CNT, 32'h0);
			if (k == 2) begin
				check(e, 1'b1);
				check(r, 32'h0);
			end else begin
				check(r, r1);
			end
			{wait_mode, stop_mode, break_active} <= 3'b000;
			apb(1'b0, ADDR_CNT, 32'h0);
			check(r - r0 > 32'd20, k == 2);
		end
		wr(ADDR_CCS + 12'h4, 32'h44);
		break_active <= 1'b1;
		i_tpwm_pins_model.pin_pulse(1);
		break_active <= 1'b0;
		rd(ADDR_CCS + 12'h4, 32'h44);
		check(irq, 1'b0);
		i_tpwm_pins_model.pin_pulse(1);
		rd(ADDR_CCS + 12'h4, 32'hc4);
		check(irq, 1'b1);
		close_out;
	end
endmodule
`default_nettype wire
